// ===== hdl/lvc_pkg.sv
// Contract
// (RL1) detector works only while enabled; select bit picks high or low trip
// (RL2) stop entry switches detector off unless stop enable bit is set
// (RL3) with both enables set only the lightest stop mode is granted
// (RL4) reset asserted at power-up and while power-on detector reports low supply
// (RL5) after power-on, hold reset until supply above the low trip level
// (RL6) power-on reset sets both power-on and low-voltage cause flags
// (RL7) reset enable set plus low-voltage detection produces a system reset
// (RL8) after low-voltage reset, hold until supply above the selected trip level
// (RL9) low-voltage reset sets the low-voltage cause flag
// (RL10) enabled, irq enabled, reset disabled: detection sets flag and raises irq
// (RL11) warning flag for supply nearing detect level, never raises an interrupt
// (RL12) warning trip level picked high or low by warning select bit
// (RL13) reset cause register: power-on at bit 7, low-voltage at bit 1
// (RL14) irq holds while flag and enable set; software acknowledges to clear
package lvc_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] POWER_CONTROL_ONE_OFS    = 8'h00;
  localparam logic [7:0] POWER_CONTROL_TWO_OFS    = 8'h04;
  localparam logic [7:0] RESET_CAUSE_REGISTER_OFS = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFS           = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS             = 8'h10;
  // power_control_one fields
  localparam int FLAG_BIT     = 7;
  localparam int ACK_BIT      = 6;
  localparam int IRQ_EN_BIT   = 5;
  localparam int RST_EN_BIT   = 4;
  localparam int STOP_EN_BIT  = 3;
  localparam int DET_EN_BIT   = 2;
  // power_control_two fields
  localparam int WARN_BIT     = 7;
  localparam int WARN_ACK_BIT = 6;
  localparam int TRIP_SEL_BIT = 5;
  localparam int WSEL_BIT     = 4;
  // reset cause fields
  localparam int CAUSE_POR_BIT = 7;
  localparam int CAUSE_LVD_BIT = 1;
  // interrupt status bits
  localparam int EV_DETECT = 0;
  localparam int EV_WARN   = 1;
  localparam int EV_RESET  = 2;
  localparam int EV_W      = 3;
  // reset values
  localparam logic [7:0] CTRL_ONE_RST = 8'h1C;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  // stop mode request codes
  typedef enum logic [1:0] {
    LVC_RUN   = 2'b00,
    LVC_STOP3 = 2'b01,
    LVC_STOP2 = 2'b11,
    LVC_STOP1 = 2'b10
  } lvc_stop_type;
  // reset sequencer states
  typedef enum logic [1:0] {
    LVC_ST_HOLD_POR = 2'b00,
    LVC_ST_RUN      = 2'b01,
    LVC_ST_HOLD_LVD = 2'b11
  } lvc_state_type;
  // analog comparator bundle
  typedef struct packed {
    logic por_low;
    logic above_low_trip;
    logic above_high_trip;
    logic warn_low_trip;
    logic warn_high_trip;
  } lvc_analog_type;
  // comparator controls
  typedef struct packed {
    logic det_on;
    logic trip_high;
    logic warn_high;
  } lvc_acfg_type;
endpackage

// ===== hdl/lvc_control.sv
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module lvc_control (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   hsel,
  input  wire logic [7:0]             haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire lvc_pkg::lvc_analog_type analog,
  output lvc_pkg::lvc_acfg_type        acfg,
  input  wire lvc_pkg::lvc_stop_type   stop_req,
  output lvc_pkg::lvc_stop_type        stop_grant,
  output logic                        chip_reset,
  output logic                        low_supply_irq,
  output logic                        irq
);
  import lvc_pkg::*;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic detector_enable_q, detector_stop_enable_q, detect_reset_enable_q;
  logic detect_irq_enable_q, low_supply_flag_q, supply_warning_q;
  logic detect_trip_select_q, warning_trip_select_q;
  logic cause_por_q, low_supply_cause_q;
  logic [EV_W-1:0] ev_status_q, ev_mask_q;
  lvc_state_type state_q, state_d;
  logic [7:0] wr_addr_q;
  logic       wr_pend_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire addr_ok   = hsel && hready && htrans[1];
  wire wr_accept = addr_ok && hwrite;
  wire rd_accept = addr_ok && !hwrite;
  wire wr_one    = wr_pend_q && (wr_addr_q == POWER_CONTROL_ONE_OFS);
  wire wr_two    = wr_pend_q && (wr_addr_q == POWER_CONTROL_TWO_OFS);
  wire wr_stat   = wr_pend_q && (wr_addr_q == IRQ_STATUS_OFS);
  wire wr_mask   = wr_pend_q && (wr_addr_q == IRQ_MASK_OFS);

  // zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------
  // detector gating
  // ---------------------------------------------------------------
  wire in_stop   = (stop_req != LVC_RUN);
  wire det_on    = detector_enable_q && (!in_stop || detector_stop_enable_q); // [RL1] [RL2]
  wire keep_det  = detector_enable_q && detector_stop_enable_q;
  wire low_cond  = det_on && (detect_trip_select_q ? !analog.above_high_trip
                                                   : !analog.above_low_trip);
  wire warn_cond = warning_trip_select_q ? analog.warn_high_trip : analog.warn_low_trip; // [RL12]
  wire lvd_trip  = (state_q == LVC_ST_RUN) && low_cond && detect_reset_enable_q;  // [RL7]
  wire irq_event = low_cond && detect_irq_enable_q && !detect_reset_enable_q;     // [RL10]
  wire flag_ev   = low_cond && !detect_reset_enable_q;

  // comparator steering, trip chosen by select bit
  assign acfg.det_on    = det_on;                // [RL1]
  assign acfg.trip_high = detect_trip_select_q;  // [RL1]
  assign acfg.warn_high = warning_trip_select_q; // [RL12]

  // deep stops refused while the detector must stay powered
  assign stop_grant = (keep_det && in_stop) ? LVC_STOP3 : stop_req; // [RL3]

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      LVC_ST_HOLD_POR: if (!analog.por_low && analog.above_low_trip) state_d = LVC_ST_RUN; // [RL5]
      LVC_ST_RUN: begin
        if (analog.por_low) state_d = LVC_ST_HOLD_POR; // [RL4]
        else if (lvd_trip) state_d = LVC_ST_HOLD_LVD;  // [RL7]
      end
      LVC_ST_HOLD_LVD: begin
        if (analog.por_low) state_d = LVC_ST_HOLD_POR;
        else if (detect_trip_select_q ? analog.above_high_trip : analog.above_low_trip)
          state_d = LVC_ST_RUN; // [RL8]
      end
      default: state_d = LVC_ST_HOLD_POR;
    endcase
  end

  // power-up state holds reset; analog por also asserts it at once
  assign chip_reset = (state_q != LVC_ST_RUN) || analog.por_low || lvd_trip; // [RL4] [RL7]

  always_ff @(posedge clk) begin
    if (rst) state_q <= LVC_ST_HOLD_POR;
    else     state_q <= state_d;
  end

  // ---------------------------------------------------------------
  // reset causes; survive system reset, set by a new cause and never cleared
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cause_por_q        <= 1'b1; // [RL6]
      low_supply_cause_q <= 1'b1; // [RL6]
    end else if (state_q == LVC_ST_RUN && state_d == LVC_ST_HOLD_POR) begin
      cause_por_q        <= 1'b1; // [RL6]
      low_supply_cause_q <= 1'b1;
    end else if (state_q == LVC_ST_RUN && state_d == LVC_ST_HOLD_LVD) begin
      low_supply_cause_q <= 1'b1; // [RL9] por bit unaffected
    end
  end

  // ---------------------------------------------------------------
  // control bits; a chip reset reloads them like the rest of the chip
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || state_q != LVC_ST_RUN) begin
      detector_enable_q      <= CTRL_ONE_RST[DET_EN_BIT];
      detector_stop_enable_q <= CTRL_ONE_RST[STOP_EN_BIT];
      detect_reset_enable_q  <= CTRL_ONE_RST[RST_EN_BIT];
      detect_irq_enable_q    <= CTRL_ONE_RST[IRQ_EN_BIT];
    end else if (wr_one) begin
      detector_enable_q      <= hwdata[DET_EN_BIT];
      detector_stop_enable_q <= hwdata[STOP_EN_BIT];
      detect_reset_enable_q  <= hwdata[RST_EN_BIT];
      detect_irq_enable_q    <= hwdata[IRQ_EN_BIT];
    end
  end

  // trip selects survive a low-voltage reset: its release level must stay the chosen one,
  // only power-on brings them back to their reset value
  always_ff @(posedge clk) begin
    if (rst || state_q == LVC_ST_HOLD_POR) begin
      detect_trip_select_q  <= CTRL_TWO_RST[TRIP_SEL_BIT];
      warning_trip_select_q <= CTRL_TWO_RST[WSEL_BIT];
    end else if (wr_two && state_q == LVC_ST_RUN) begin
      detect_trip_select_q  <= hwdata[TRIP_SEL_BIT]; // [RL1] [RL8]
      warning_trip_select_q <= hwdata[WSEL_BIT];     // [RL12]
    end
  end

  // sticky flags: a new event wins over an acknowledge in the same cycle
  always_ff @(posedge clk) begin
    if (rst || state_q != LVC_ST_RUN) begin
      low_supply_flag_q <= 1'b0;
      supply_warning_q  <= 1'b0;
    end else begin
      low_supply_flag_q <= flag_ev || (low_supply_flag_q && !(wr_one && hwdata[ACK_BIT])); // [RL10] [RL14]
      supply_warning_q  <= warn_cond || (supply_warning_q && !(wr_two && hwdata[WARN_ACK_BIT])); // [RL11]
    end
  end

  // flag interrupt held while flag and enable both set
  assign low_supply_irq = low_supply_flag_q && detect_irq_enable_q; // [RL10] [RL14]

  // ---------------------------------------------------------------
  // system interrupt status (write one to clear) and mask (plain write)
  // ---------------------------------------------------------------
  wire [EV_W-1:0] ev_in;
  assign ev_in[EV_DETECT] = irq_event;
  assign ev_in[EV_WARN]   = 1'b0;     // warning never interrupts [RL11]
  assign ev_in[EV_RESET]  = lvd_trip;

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_status_q <= '0;
      ev_mask_q   <= '0;
    end else begin
      ev_status_q <= ev_in | (ev_status_q & ~(wr_stat ? hwdata[EV_W-1:0] : '0));
      if (wr_mask) ev_mask_q <= hwdata[EV_W-1:0];
    end
  end

  assign irq = |(ev_status_q & ev_mask_q);

  // ---------------------------------------------------------------
  // bus pipeline and read data
  // ---------------------------------------------------------------
  wire [7:0] reg_one   = {low_supply_flag_q, 1'b0, detect_irq_enable_q, detect_reset_enable_q,
                          detector_stop_enable_q, detector_enable_q, 2'b00};
  wire [7:0] reg_two   = {supply_warning_q, 1'b0, detect_trip_select_q, warning_trip_select_q, 4'h0};
  wire [7:0] reg_cause = {cause_por_q, 5'h00, low_supply_cause_q, 1'b0}; // [RL13]
  wire [7:0] rd_sel    = (haddr == POWER_CONTROL_ONE_OFS)    ? reg_one :
                         (haddr == POWER_CONTROL_TWO_OFS)    ? reg_two :
                         (haddr == RESET_CAUSE_REGISTER_OFS) ? reg_cause :
                         (haddr == IRQ_STATUS_OFS)           ? {5'h00, ev_status_q} :
                         (haddr == IRQ_MASK_OFS)             ? {5'h00, ev_mask_q} : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h00000000;
    end else begin
      wr_pend_q <= wr_accept;
      wr_addr_q <= haddr;
      if (rd_accept) hrdata <= {24'h000000, rd_sel};
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_det_off_in_stop;
    @(posedge clk) disable iff (rst) (in_stop && !detector_stop_enable_q) |-> !acfg.det_on;
  endproperty
  a_det_off_in_stop: assert property (p_det_off_in_stop) else $error("detector on in stop"); // [RL2]

  property p_no_deep_stop;
    @(posedge clk) disable iff (rst) keep_det |-> (stop_grant == LVC_RUN || stop_grant == LVC_STOP3);
  endproperty
  a_no_deep_stop: assert property (p_no_deep_stop) else $error("deep stop granted"); // [RL3]

  property p_por_reset;
    @(posedge clk) disable iff (rst) analog.por_low |-> chip_reset ##1 chip_reset;
  endproperty
  a_por_reset: assert property (p_por_reset) else $error("no reset on por"); // [RL4]

  property p_por_hold;
    @(posedge clk) disable iff (rst) (state_q == LVC_ST_HOLD_POR && !analog.above_low_trip) |=> chip_reset;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("released below low trip"); // [RL5]

  property p_por_causes;
    @(posedge clk) disable iff (rst) (state_q == LVC_ST_HOLD_POR) |-> cause_por_q && low_supply_cause_q;
  endproperty
  a_por_causes: assert property (p_por_causes) else $error("por causes missing"); // [RL6]

  property p_lvd_reset;
    @(posedge clk) disable iff (rst) lvd_trip |=> state_q == LVC_ST_HOLD_LVD || state_q == LVC_ST_HOLD_POR;
  endproperty
  a_lvd_reset: assert property (p_lvd_reset) else $error("lvd reset missed"); // [RL7]

  property p_lvd_cause;
    @(posedge clk) disable iff (rst) $rose(state_q == LVC_ST_HOLD_LVD) |-> low_supply_cause_q && reg_cause[1];
  endproperty
  a_lvd_cause: assert property (p_lvd_cause) else $error("lvd cause missing"); // [RL9]

  property p_flag_irq;
    @(posedge clk) disable iff (rst || state_q != LVC_ST_RUN)
      (irq_event && !wr_one && state_d == LVC_ST_RUN) |=> low_supply_flag_q && low_supply_irq;
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("flag irq missed"); // [RL10]

  property p_irq_stays;
    @(posedge clk) disable iff (rst) (low_supply_irq && !wr_one && state_q == LVC_ST_RUN && state_d == LVC_ST_RUN)
      |=> low_supply_irq;
  endproperty
  a_irq_stays: assert property (p_irq_stays) else $error("irq dropped"); // [RL14]

  // detector power follows its enable; stop enable keeps it alive
  property p_det_needs_enable;
    @(posedge clk) disable iff (rst) !detector_enable_q |-> !acfg.det_on;
  endproperty
  a_det_needs_enable: assert property (p_det_needs_enable) else $error("detector on while disabled"); // [RL1]

  property p_stop_keeps_det;
    @(posedge clk) disable iff (rst) (detector_enable_q && detector_stop_enable_q) |-> acfg.det_on;
  endproperty
  a_stop_keeps_det: assert property (p_stop_keeps_det) else $error("detector dropped in stop"); // [RL2]

  property p_grant_pass;
    @(posedge clk) disable iff (rst) !keep_det |-> stop_grant == stop_req;
  endproperty
  a_grant_pass: assert property (p_grant_pass) else $error("stop request altered"); // [RL3]

  // a high trip select must keep the chip in reset between the two levels
  property p_lvd_hold;
    @(posedge clk) disable iff (rst)
      (state_q == LVC_ST_HOLD_LVD && detect_trip_select_q && !analog.above_high_trip) |=> chip_reset;
  endproperty
  a_lvd_hold: assert property (p_lvd_hold) else $error("released below selected trip"); // [RL8]

  // reset mode must never leave the interrupt flag behind
  property p_flag_reset_mode;
    @(posedge clk) disable iff (rst)
      (detect_reset_enable_q && !low_supply_flag_q && !wr_one) |=> !low_supply_flag_q;
  endproperty
  a_flag_reset_mode: assert property (p_flag_reset_mode) else $error("flag set in reset mode"); // [RL10]

  // warning sets its flag but never reaches the interrupt status
  property p_warn_set;
    @(posedge clk) disable iff (rst)
      (warn_cond && state_q == LVC_ST_RUN && state_d == LVC_ST_RUN) |=> supply_warning_q;
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning flag missed"); // [RL11]

  property p_warn_no_irq;
    @(posedge clk) disable iff (rst) !ev_status_q[EV_WARN];
  endproperty
  a_warn_no_irq: assert property (p_warn_no_irq) else $error("warning raised status"); // [RL11]

  c_lvd_reset: cover property (@(posedge clk) disable iff (rst) lvd_trip);
  c_flag_set:  cover property (@(posedge clk) disable iff (rst) $rose(low_supply_flag_q));
  c_warn_set:  cover property (@(posedge clk) disable iff (rst) $rose(supply_warning_q));
  c_stop_held: cover property (@(posedge clk) disable iff (rst) keep_det && stop_req == LVC_STOP1);
  c_hold_high: cover property (@(posedge clk) disable iff (rst) state_q == LVC_ST_HOLD_LVD && detect_trip_select_q);
endmodule
`default_nettype wire

// ===== testbench/lvc_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------
// comparator model: supply given as a plain level code
// -----------------------------------------------------------------
module lvc_analog_model #(
  parameter int POR_LVL   = 10,
  parameter int LOW_TRIP  = 20,
  parameter int HIGH_TRIP = 30,
  parameter int WARN_LOW  = 25,
  parameter int WARN_HIGH = 35
) (
  input  wire lvc_pkg::lvc_acfg_type acfg,
  input  wire logic [7:0]            supply,
  output lvc_pkg::lvc_analog_type    analog
);
  import lvc_pkg::*;
  // power-on comparator runs without any enable
  assign analog.por_low = (supply < POR_LVL);
  // a switched-off detector reports no margin, so a design that ignores det_on resets
  assign analog.above_low_trip  = acfg.det_on && (supply > LOW_TRIP);
  assign analog.above_high_trip = acfg.det_on && (supply > HIGH_TRIP);
  // warning comparators, also dead while the detector is off
  assign analog.warn_low_trip  = acfg.det_on && (supply < WARN_LOW);
  assign analog.warn_high_trip = acfg.det_on && (supply < WARN_HIGH);
endmodule
`default_nettype wire

// ===== testbench/low_voltage_detect_control_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module low_voltage_detect_control_test;
  import lvc_pkg::*;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic           hsel = 1'b0;
  logic           hwrite = 1'b0;
  logic [7:0]     haddr = 8'h00;
  logic [1:0]     htrans = 2'b00;
  logic [2:0]     hsize = 3'b010;
  logic [31:0]    hwdata = 32'h0;
  logic [7:0]     supply = 8'h00;
  lvc_stop_type   stop_req = LVC_RUN;
  wire logic      hready;
  logic           hreadyout, hresp, chip_reset, low_supply_irq, irq;
  logic [31:0]    hrdata;
  lvc_analog_type analog;
  lvc_acfg_type   acfg;
  lvc_stop_type   stop_grant, exp_g;
  int             err_total = 0;
  int             n_compared = 0;
  int             seed = 14;
  logic [31:0]    r;
  assign hready = hreadyout;

  lvc_control lvc_control_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .analog(analog), .acfg(acfg), .stop_req(stop_req), .stop_grant(stop_grant), .chip_reset(chip_reset),
    .low_supply_irq(low_supply_irq), .irq(irq));
  lvc_analog_model lvc_analog_model_i (.acfg(acfg), .supply(supply), .analog(analog));

  // 200 MHz
  always #2.5 clk = ~clk;

  // -----------------------------------------------------------------
  // bus and timing helpers
  // -----------------------------------------------------------------
  task automatic final_report();
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // the master polls hreadyout for up to 50 cycles; a lost answer ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      final_report();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, {24'h0, d}, x);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] ex);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    `CHK(nm, {24'h0, ex}, x)
  endtask

  // reset release has no fixed latency here, so poll with a bound
  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    while (chip_reset !== v && n < 20) begin
      step(1);
      n++;
    end
    `CHK("chip_reset", v, chip_reset)
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    step(2);
    `CHK("por_hold", 1'b1, chip_reset)
    supply <= 8'd15;
    step(3);
    `CHK("below_low_trip_hold", 1'b1, chip_reset)
    supply <= 8'd50;
    wait_rst(1'b0);
    rd_chk("cause_after_por", RESET_CAUSE_REGISTER_OFS, 8'h82);
    rd_chk("ctrl_one_reset", POWER_CONTROL_ONE_OFS, CTRL_ONE_RST);
    rd_chk("ctrl_two_reset", POWER_CONTROL_TWO_OFS, CTRL_TWO_RST);
    // interrupt path: low trip keeps quiet at 25, high trip fires
    wr(POWER_CONTROL_ONE_OFS, 8'h24);
    supply <= 8'd25;
    step(3);
    `CHK("low_trip_quiet", 1'b0, low_supply_irq)
    wr(POWER_CONTROL_TWO_OFS, 8'h20);
    step(1);
    `CHK("trip_high", 1'b1, acfg.trip_high)
    step(2);
    `CHK("low_supply_irq", 1'b1, low_supply_irq)
    rd_chk("flag_set", POWER_CONTROL_ONE_OFS, 8'hA4);
    wr(IRQ_MASK_OFS, 8'h01);
    step(1);
    `CHK("irq_unmasked", 1'b1, irq)
    wr(IRQ_MASK_OFS, 8'h00);
    step(1);
    `CHK("irq_masked", 1'b0, irq)
    supply <= 8'd50;
    wr(POWER_CONTROL_ONE_OFS, 8'h64);
    step(2);
    `CHK("irq_after_ack", 1'b0, low_supply_irq)
    rd_chk("flag_clear", POWER_CONTROL_ONE_OFS, 8'h24);
    wr(IRQ_MASK_OFS, 8'h07);
    step(1);
    `CHK("status_sticky", 1'b1, irq)
    rd_chk("status_event", IRQ_STATUS_OFS, 8'h01);
    wr(IRQ_STATUS_OFS, 8'h01);
    step(1);
    `CHK("status_cleared", 1'b0, irq)
    // detector disabled: low supply must go unnoticed
    wr(POWER_CONTROL_ONE_OFS, 8'h20);
    supply <= 8'd15;
    step(3);
    `CHK("det_off", 1'b0, acfg.det_on)
    `CHK("det_off_irq", 1'b0, low_supply_irq)
    // warning band never interrupts, even fully unmasked
    wr(POWER_CONTROL_TWO_OFS, 8'h10);
    wr(POWER_CONTROL_ONE_OFS, 8'h04);
    supply <= 8'd32;
    step(1);
    `CHK("warn_high", 1'b1, acfg.warn_high)
    `CHK("trip_low", 1'b0, acfg.trip_high)
    step(3);
    `CHK("warn_no_irq", 1'b0, irq)
    rd_chk("warn_status", IRQ_STATUS_OFS, 8'h00);
    rd_chk("warn_flag", POWER_CONTROL_TWO_OFS, 8'h90);
    // stop modes over every request code and enable pair, random irq enable
    supply <= 8'd50;
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      wr(POWER_CONTROL_ONE_OFS, {2'b00, r[0], 1'b0, i[3], i[2], 2'b00});
      stop_req <= lvc_stop_type'(i[1:0]);
      step(1);
      exp_g = (i[2] && i[3] && i[1:0] != 2'b00) ? LVC_STOP3 : lvc_stop_type'(i[1:0]);
      `CHK("stop_grant", exp_g, stop_grant)
      `CHK("stop_det_on", i[2] && (i[1:0] == 2'b00 || i[3]), acfg.det_on)
      stop_req <= LVC_RUN;
    end
    // low-voltage reset and its hold
    wr(POWER_CONTROL_ONE_OFS, 8'h1C);
    wr(POWER_CONTROL_TWO_OFS, 8'h20);
    supply <= 8'd15;
    step(1);
    `CHK("lvd_reset", 1'b1, chip_reset)
    supply <= 8'd18;
    step(4);
    `CHK("lvd_hold", 1'b1, chip_reset)
    supply <= 8'd25;
    step(4);
    `CHK("lvd_hold_high", 1'b1, chip_reset)
    supply <= 8'd50;
    wait_rst(1'b0);
    rd_chk("cause_after_lvd", RESET_CAUSE_REGISTER_OFS, 8'h82);
    rd_chk("status_lvd", IRQ_STATUS_OFS, 8'h04);
    rd_chk("unmapped", 8'h20, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
